// ### ifr_pkg.sv
package ifr_pkg;

	// bus geometry
	localparam int DATA_W        = 32;
	localparam int REG_W         = 8;
	localparam int EVT_W         = 6;
	localparam int NUM_FLAG_REGS = 4;

	// register indices, byte address is four times the index
	localparam logic [7:0] IDX_FLAGS_A    = 8'h88;
	localparam logic [7:0] IDX_FLAGS_B    = 8'h98;
	localparam logic [7:0] IDX_FLAGS_C    = 8'h9B;
	localparam logic [7:0] IDX_CONTROL    = 8'hC8;
	localparam logic [7:0] IDX_EVT_STATUS = 8'hD0;
	localparam logic [7:0] IDX_EVT_MASK   = 8'hD1;

	// slots of the flag register array
	localparam int SLOT_A    = 0;
	localparam int SLOT_B    = 1;
	localparam int SLOT_C    = 2;
	localparam int SLOT_CTRL = 3;

	// field positions in the first flag register
	localparam int BIT_SERIAL1     = 7;
	localparam int BIT_CONVERTER   = 5;
	localparam int BIT_SERIAL0     = 3;
	localparam int BIT_KEEP_ONE_B  = 2;
	localparam int BIT_RF_FIFO_ERR = 1;
	localparam int BIT_KEEP_ONE_A  = 0;

	// field positions of the paired flags in the second and third registers
	localparam int BIT_PAIR_HI = 1;
	localparam int BIT_PAIR_LO = 0;

	// reset values
	localparam logic [REG_W-1:0] RST_FLAGS_A = 8'h05;
	localparam logic [REG_W-1:0] RST_FLAGS_B = 8'h00;
	localparam logic [REG_W-1:0] RST_FLAGS_C = 8'h00;
	localparam logic [REG_W-1:0] RST_CONTROL = 8'h60;
	localparam logic [EVT_W-1:0] RST_EVT     = 6'h00;

	// bits that hold storage; the rest read as zero
	localparam logic [REG_W-1:0] WMASK_A    = 8'hFF;
	localparam logic [REG_W-1:0] WMASK_PAIR = 8'hC3;
	localparam logic [REG_W-1:0] WMASK_CTRL = 8'hFF;

	// per-slot tables for the flag register array
	localparam logic [REG_W-1:0] FLAG_RST [NUM_FLAG_REGS] = '{RST_FLAGS_A, RST_FLAGS_B, RST_FLAGS_C, RST_CONTROL};
	localparam logic [REG_W-1:0] FLAG_WMASK [NUM_FLAG_REGS] = '{WMASK_A, WMASK_PAIR, WMASK_PAIR, WMASK_CTRL};

	// one bit per interrupt source
	typedef struct packed {
		logic serial1;
		logic converter;
		logic serial0;
		logic rf_fifo_err;
		logic cipher;
		logic radio_general;
	} ifr_evt_t;

endpackage

// ### ifr_flag_reg.sv
`timescale 1ns/100ps
module ifr_flag_reg #(
	parameter int           W       = 8,
	parameter logic [W-1:0] RST_VAL = '0,
	parameter logic [W-1:0] WR_MASK = '1
) (
	// clock and reset
	input  wire logic         clk_i,
	input  wire logic         rst_i,
	input  wire logic         ce_i,
	// hardware set and clear, one bit each
	input  wire logic [W-1:0] hw_set_i,
	input  wire logic [W-1:0] hw_clr_i,
	// software write
	input  wire logic         sw_we_i,
	input  wire logic [W-1:0] sw_wdata_i,
	// stored value
	output logic      [W-1:0] q_o
);

	logic [W-1:0] q_ff;
	logic [W-1:0] nxt_q;
	logic [W-1:0] kept;

	// software write replaces writable bits, otherwise hardware clear acts
	assign kept  = sw_we_i ? ((sw_wdata_i & WR_MASK) | (q_ff & ~WR_MASK)) : (q_ff & ~hw_clr_i);
	// a source event wins over any clear in the same cycle
	assign nxt_q = (hw_set_i & WR_MASK) | kept;
	assign q_o   = q_ff;

	// storage
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			q_ff <= RST_VAL;
		end else if (ce_i) begin
			q_ff <= nxt_q;
		end
	end

endmodule // ifr_flag_reg

// ### ifr_top.sv
// Register access over Wishbone is this design's own decision.
`timescale 1ns/100ps
// Functional notes
// - a serial channel 1 receive event sets bit 7 of the first flag register.
// - a converter event sets bit 5 of the first flag register.
// - a serial channel 0 receive event sets bit 3 of the first flag register.
// - a radio FIFO error event sets bit 1 of the first flag register.
// - the serial, converter and radio FIFO error flags clear when the CPU takes their vector.
// - bits 2 and 0 of the first flag register and bits 6 and 5 of the control register reset to one, and a software write can clear them.
// - the cipher pair sits in bits 1 and 0 of the second flag register and either bit requests service.
// - a cipher event sets both cipher flags together.
// - the radio general pair sits in bits 1 and 0 of the third flag register and either bit requests service.
// - a radio general event sets both radio general flags together.
// - flags set on their source event whatever the enable bits say.
// - a set flag whose interrupt is enabled raises a vector request on the next cycle.
module ifr_top #(
	parameter int ADR_W = 12
) (
	// clock, reset, clock enable
	input  wire logic                       clk_i,
	input  wire logic                       rst_i,
	input  wire logic                       ce_i,
	// wishbone slave
	input  wire logic                       cyc_i,
	input  wire logic                       stb_i,
	input  wire logic                       we_i,
	input  wire logic [3:0]                 sel_i,
	input  wire logic [ADR_W-1:0]           adr_i,
	input  wire logic [ifr_pkg::DATA_W-1:0] dat_i,
	output logic      [ifr_pkg::DATA_W-1:0] dat_o,
	output logic                            ack_o,
	// peripheral event strobes and cpu vectoring
	input  wire ifr_pkg::ifr_evt_t          evt_i,
	input  wire ifr_pkg::ifr_evt_t          vector_taken_i,
	input  wire ifr_pkg::ifr_evt_t          irq_enable_i,
	// requests toward the vectoring logic
	output ifr_pkg::ifr_evt_t               svc_req_o,
	// summary interrupt
	output logic                            irq_o
);

	localparam int RW = ifr_pkg::REG_W;
	localparam int EW = ifr_pkg::EVT_W;
	localparam int NR = ifr_pkg::NUM_FLAG_REGS;

	// one-hot select: flag slots 0..3, then status, then mask
	function automatic logic [NR+1:0] reg_hit(input logic [ADR_W-1:0] adr);
		logic [NR+1:0] hit;
		logic          top_ok;
		hit    = '0;
		top_ok = (adr[ADR_W-1:10] == '0);
		hit[ifr_pkg::SLOT_A]    = top_ok && (adr[9:2] == ifr_pkg::IDX_FLAGS_A);
		hit[ifr_pkg::SLOT_B]    = top_ok && (adr[9:2] == ifr_pkg::IDX_FLAGS_B);
		hit[ifr_pkg::SLOT_C]    = top_ok && (adr[9:2] == ifr_pkg::IDX_FLAGS_C);
		hit[ifr_pkg::SLOT_CTRL] = top_ok && (adr[9:2] == ifr_pkg::IDX_CONTROL);
		hit[NR]                 = top_ok && (adr[9:2] == ifr_pkg::IDX_EVT_STATUS);
		hit[NR+1]               = top_ok && (adr[9:2] == ifr_pkg::IDX_EVT_MASK);
		return hit;
	endfunction

	logic                       ack_ff;
	logic [ifr_pkg::DATA_W-1:0] dat_ff;
	logic [EW-1:0]              status_ff;
	logic [EW-1:0]              mask_ff;
	ifr_pkg::ifr_evt_t          svc_req_ff;

	logic [NR+1:0]              hit;
	logic                       bus_req;
	logic                       bus_wr;
	logic [RW-1:0]              flag_q   [NR];
	logic [RW-1:0]              flag_set [NR];
	logic [RW-1:0]              flag_clr [NR];
	logic [RW-1:0]              rd_byte;
	logic [EW-1:0]              evt_bits;
	logic [EW-1:0]              status_clr;
	logic [EW-1:0]              nxt_status;
	ifr_pkg::ifr_evt_t          pending;

	// bus decode; writes land at the edge where ack is high
	assign hit     = reg_hit(adr_i);
	assign bus_req = cyc_i && stb_i;
	assign bus_wr  = bus_req && we_i && ack_ff && sel_i[0];

	// event strobes into the first flag register
	assign flag_set[ifr_pkg::SLOT_A] = (RW'(evt_i.serial1) << ifr_pkg::BIT_SERIAL1)
	                                 | (RW'(evt_i.converter) << ifr_pkg::BIT_CONVERTER)
	                                 | (RW'(evt_i.serial0) << ifr_pkg::BIT_SERIAL0)
	                                 | (RW'(evt_i.rf_fifo_err) << ifr_pkg::BIT_RF_FIFO_ERR);
	// paired sources set both bits at once
	assign flag_set[ifr_pkg::SLOT_B] = (RW'(evt_i.cipher) << ifr_pkg::BIT_PAIR_HI)
	                                 | (RW'(evt_i.cipher) << ifr_pkg::BIT_PAIR_LO);
	assign flag_set[ifr_pkg::SLOT_C] = (RW'(evt_i.radio_general) << ifr_pkg::BIT_PAIR_HI)
	                                 | (RW'(evt_i.radio_general) << ifr_pkg::BIT_PAIR_LO);
	assign flag_set[ifr_pkg::SLOT_CTRL] = '0;

	// vector taken clears only the first register's source flags
	assign flag_clr[ifr_pkg::SLOT_A] = (RW'(vector_taken_i.serial1) << ifr_pkg::BIT_SERIAL1)
	                                 | (RW'(vector_taken_i.converter) << ifr_pkg::BIT_CONVERTER)
	                                 | (RW'(vector_taken_i.serial0) << ifr_pkg::BIT_SERIAL0)
	                                 | (RW'(vector_taken_i.rf_fifo_err) << ifr_pkg::BIT_RF_FIFO_ERR);
	// paired flags have no hardware clear, software writes zero
	assign flag_clr[ifr_pkg::SLOT_B]    = '0;
	assign flag_clr[ifr_pkg::SLOT_C]    = '0;
	assign flag_clr[ifr_pkg::SLOT_CTRL] = '0;

	// flag register array, keep-one bits reset to one
	for (genvar g = 0; g < NR; g++) begin : g_flag
		ifr_flag_reg #(
			.W       (RW),
			.RST_VAL (ifr_pkg::FLAG_RST[g]),
			.WR_MASK (ifr_pkg::FLAG_WMASK[g])
		) u_flag (
			.clk_i      (clk_i),
			.rst_i      (rst_i),
			.ce_i       (ce_i),
			.hw_set_i   (flag_set[g]),
			.hw_clr_i   (flag_clr[g]),
			.sw_we_i    (bus_wr && hit[g]),
			.sw_wdata_i (dat_i[RW-1:0]),
			.q_o        (flag_q[g])
		);
	end

	// pending view per source, a one means pending
	assign pending.serial1       = flag_q[ifr_pkg::SLOT_A][ifr_pkg::BIT_SERIAL1];
	assign pending.converter     = flag_q[ifr_pkg::SLOT_A][ifr_pkg::BIT_CONVERTER];
	assign pending.serial0       = flag_q[ifr_pkg::SLOT_A][ifr_pkg::BIT_SERIAL0];
	assign pending.rf_fifo_err   = flag_q[ifr_pkg::SLOT_A][ifr_pkg::BIT_RF_FIFO_ERR];
	assign pending.cipher        = flag_q[ifr_pkg::SLOT_B][ifr_pkg::BIT_PAIR_HI]
	                             | flag_q[ifr_pkg::SLOT_B][ifr_pkg::BIT_PAIR_LO];
	assign pending.radio_general = flag_q[ifr_pkg::SLOT_C][ifr_pkg::BIT_PAIR_HI]
	                             | flag_q[ifr_pkg::SLOT_C][ifr_pkg::BIT_PAIR_LO];

	// vector request one cycle after flag and enable meet
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			svc_req_ff <= '0;
		end else if (ce_i) begin
			svc_req_ff <= pending & irq_enable_i;
		end
	end
	assign svc_req_o = svc_req_ff;

	// sticky event status, write one to clear, event wins
	assign evt_bits   = evt_i;
	assign status_clr = (bus_wr && hit[NR]) ? dat_i[EW-1:0] : '0;
	assign nxt_status = (status_ff & ~status_clr) | evt_bits;

	// status and mask storage
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			status_ff <= ifr_pkg::RST_EVT;
			mask_ff   <= ifr_pkg::RST_EVT;
		end else if (ce_i) begin
			status_ff <= nxt_status;
			if (bus_wr && hit[NR+1]) begin
				mask_ff <= dat_i[EW-1:0];
			end
		end
	end
	assign irq_o = |(status_ff & mask_ff);

	// read selection, unmapped reads give zero
	assign rd_byte = ({RW{hit[ifr_pkg::SLOT_A]}} & flag_q[ifr_pkg::SLOT_A])
	               | ({RW{hit[ifr_pkg::SLOT_B]}} & flag_q[ifr_pkg::SLOT_B])
	               | ({RW{hit[ifr_pkg::SLOT_C]}} & flag_q[ifr_pkg::SLOT_C])
	               | ({RW{hit[ifr_pkg::SLOT_CTRL]}} & flag_q[ifr_pkg::SLOT_CTRL])
	               | ({RW{hit[NR]}} & RW'(status_ff))
	               | ({RW{hit[NR+1]}} & RW'(mask_ff));

	// one wait state: ack and read data register on the same edge
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_ff <= 1'b0;
			dat_ff <= '0;
		end else if (ce_i) begin
			ack_ff <= bus_req && !ack_ff;
			if (bus_req && !ack_ff) begin
				dat_ff <= {{(ifr_pkg::DATA_W-RW){1'b0}}, rd_byte};
			end
		end
	end
	assign ack_o = ack_ff;
	assign dat_o = dat_ff;

endmodule // ifr_top

// ### ifr_assertions.sv
`timescale 1ns/100ps
module ifr_chk #(
	parameter int ADR_W = 12
) (
	// clock, reset, clock enable
	input wire logic                       clk_i,
	input wire logic                       rst_i,
	input wire logic                       ce_i,
	// wishbone slave
	input wire logic                       cyc_i,
	input wire logic                       stb_i,
	input wire logic                       we_i,
	input wire logic [3:0]                 sel_i,
	input wire logic [ADR_W-1:0]           adr_i,
	input wire logic [ifr_pkg::DATA_W-1:0] dat_i,
	input wire logic [ifr_pkg::DATA_W-1:0] dat_o,
	input wire logic                       ack_o,
	// events, vectoring, requests
	input wire ifr_pkg::ifr_evt_t          evt_i,
	input wire ifr_pkg::ifr_evt_t          vector_taken_i,
	input wire ifr_pkg::ifr_evt_t          irq_enable_i,
	input wire ifr_pkg::ifr_evt_t          svc_req_o,
	input wire logic                       irq_o
);
	// read of a paired flag register
	wire logic pair_rd = ack_o && !we_i
	                     && (adr_i[9:2] == ifr_pkg::IDX_FLAGS_B || adr_i[9:2] == ifr_pkg::IDX_FLAGS_C);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	ack_pulse_a: assert property (ack_o && ce_i |=> !ack_o) else $error("ack held too long");
	ack_prompt_a: assert property (cyc_i && stb_i && !ack_o && ce_i |=> ack_o) else $error("ack missing");
	reset_quiet_a: assert property ($fell(rst_i) |-> !ack_o && !irq_o && svc_req_o == '0)
		else $error("outputs active after reset");
	set_req_a: assert property (evt_i.serial1 && ce_i ##1 irq_enable_i.serial1 && ce_i |=> svc_req_o.serial1)
		else $error("serial1 event gave no request");
	pair_req_a: assert property (evt_i.cipher && ce_i ##1 irq_enable_i.cipher && ce_i |=> svc_req_o.cipher)
		else $error("cipher event gave no request");
	en_gate_a: assert property ($past(ce_i) |-> svc_req_o == (svc_req_o & $past(irq_enable_i)))
		else $error("request without enable");
	vec_clear_a: assert property (vector_taken_i.serial0 && !evt_i.serial0 && !(ack_o && we_i)
		|-> ##2 !svc_req_o.serial0) else $error("serial0 flag not cleared by vector");
	pair_hold_a: assert property (svc_req_o.cipher && !$past(ack_o) && !ack_o ##1 irq_enable_i.cipher
		|=> svc_req_o.cipher) else $error("cipher pair lost without write");
	pair_layout_a: assert property (pair_rd |-> dat_o[31:2] == {24'h0, dat_o[7:6], 4'h0})
		else $error("paired register unused bits set");
	cover property (ack_o && we_i);
	cover property (vector_taken_i != '0);
	cover property ($rose(irq_o));
endmodule // ifr_chk

bind ifr_top ifr_chk #(.ADR_W(ADR_W)) u_chk (.clk_i, .rst_i, .ce_i, .cyc_i, .stb_i, .we_i, .sel_i, .adr_i,
	.dat_i, .dat_o, .ack_o, .evt_i, .vector_taken_i, .irq_enable_i, .svc_req_o, .irq_o);

// ### ifr_cpu_model.sv
`timescale 1ns/100ps
module ifr_cpu_model (
	// clock and reset
	input  wire logic              clk_i,
	input  wire logic              rst_i,
	// bench commands, enables, block requests
	input  wire ifr_pkg::ifr_evt_t fire_i,
	input  wire ifr_pkg::ifr_evt_t enable_i,
	input  wire ifr_pkg::ifr_evt_t svc_req_i,
	// strobes toward the block
	output ifr_pkg::ifr_evt_t      evt_o,
	output ifr_pkg::ifr_evt_t      vector_taken_o
);
	ifr_pkg::ifr_evt_t evt_ff, vec_ff, seen_ff;
	// one event strobe per command, one vector call per fresh enabled request
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			evt_ff <= '0;
			vec_ff <= '0;
			seen_ff <= '0;
		end else begin
			evt_ff <= fire_i;
			vec_ff <= svc_req_i & enable_i & ~seen_ff;
			seen_ff <= svc_req_i;
		end
	end
	assign evt_o = evt_ff;
	assign vector_taken_o = vec_ff;
endmodule // ifr_cpu_model

// ### interrupt_flag_registers_bench.sv
`timescale 1ns/100ps
module interrupt_flag_registers_bench;
	logic              clk_i = 0, rst_i = 1, cyc = 0, we_i = 0, ce = 1'b1, ack_o, irq_o;
	logic [11:0]       adr_i = 12'h000;
	logic [31:0]       dat_i = 32'h0, dat_o, rd;
	ifr_pkg::ifr_evt_t evt, vt, svc, en = '0, fire = '0;
	int                errors = 0, n_tests = 0, tick = 0;
	// register byte addresses
	localparam logic [11:0] RA = 12'h220, RB = 12'h260, RC = 12'h26C, RT = 12'h320, RS = 12'h340, RM = 12'h344;
	ifr_top u_dut (.clk_i, .rst_i, .ce_i(ce), .cyc_i(cyc), .stb_i(cyc), .we_i, .sel_i(4'hF), .adr_i, .dat_i,
		.dat_o, .ack_o, .evt_i(evt), .vector_taken_i(vt), .irq_enable_i(en), .svc_req_o(svc), .irq_o);
	ifr_cpu_model u_cpu (.clk_i, .rst_i, .fire_i(fire), .enable_i(en), .svc_req_i(svc), .evt_o(evt),
		.vector_taken_o(vt));
	// clock and cycle ceiling
	initial forever #2 clk_i = ~clk_i;
	always @(posedge clk_i) begin
		tick++;
		if (tick == 4000) begin
			errors++;
			end_sim();
		end
	end
	task automatic end_sim;
		if (errors == 0 && n_tests > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			errors++;
			$display("[ERR] %s exp %h got %h", nm, e, g);
		end
	endtask
	// one classic wishbone cycle, held until ack is sampled
	task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk_i);
		cyc <= 1;
		we_i <= w;
		adr_i <= a;
		dat_i <= d;
		do @(posedge clk_i); while (ack_o !== 1'b1);
		rd = dat_o;
		cyc <= 0;
		we_i <= 0;
	endtask
	task automatic rc(input logic [11:0] a, input logic [31:0] e, input string nm);
		wb(0, a, 32'h0);
		chk(nm, e, rd);
	endtask
	task automatic pulse(input ifr_pkg::ifr_evt_t f);
		@(posedge clk_i);
		fire <= f;
		@(posedge clk_i);
		fire <= '0;
	endtask
	initial begin
		repeat (2) @(posedge clk_i);
		rst_i <= 0;
		rc(RA, 32'h05, "flags_a reset");
		rc(RB, 32'h00, "flags_b reset");
		rc(RC, 32'h00, "flags_c reset");
		rc(RT, 32'h60, "control reset");
		// each single flag source, set while disabled, then vectored
		for (int i = 0; i < 4; i++) begin
			pulse(6'h20 >> i);
			rc(RA, 32'h05 | (32'h80 >> (2 * i)), "flags_a set");
			en <= 6'h20 >> i;
			for (int k = 0; k < 20 && vt == '0; k++) @(posedge clk_i);
			chk("vector", 32'h20 >> i, 32'(vt));
			rc(RA, 32'h05, "flags_a vectored");
			en <= '0;
		end
		// enable already on: request, vector clears serial1, cipher pair stays
		pulse(6'h22);
		en <= 6'h22;
		rc(RB, 32'h03, "flags_b enabled");
		rc(RA, 32'h05, "flags_a auto cleared");
		en <= '0;
		wb(1, RB, 32'h00);
		pulse(6'h02);
		rc(RB, 32'h03, "flags_b event");
		pulse(6'h01);
		rc(RC, 32'h03, "flags_c event");
		wb(1, RB, 32'hFF);
		rc(RB, 32'hC3, "flags_b write");
		wb(1, RB, 32'h01);
		en <= 6'h03;
		repeat (3) @(posedge clk_i);
		chk("svc pair", 32'h03, 32'(svc));
		wb(1, RB, 32'h00);
		repeat (2) @(posedge clk_i);
		chk("svc cipher off", 32'h01, 32'(svc));
		en <= '0;
		wb(1, RA, 32'hFA);
		rc(RA, 32'hFA, "flags_a write");
		wb(1, RA, 32'h05);
		wb(1, RT, 32'h60);
		rc(RS, 32'h3F, "status");
		chk("irq masked", 32'h0, 32'(irq_o));
		wb(1, RM, 32'h02);
		@(posedge clk_i);
		chk("irq unmasked", 32'h1, 32'(irq_o));
		wb(1, RS, 32'h02);
		@(posedge clk_i);
		chk("irq cleared", 32'h0, 32'(irq_o));
		rc(RS, 32'h3D, "status cleared");
		// clock enable low freezes flags and status against an event
		ce <= 1'b0;
		pulse(6'h0A);
		@(posedge clk_i);
		ce <= 1'b1;
		rc(RA, 32'h05, "flags_a frozen");
		rc(RB, 32'h00, "flags_b frozen");
		rc(RS, 32'h3D, "status frozen");
		wb(1, 12'h004, 32'hFF);
		rc(12'h004, 32'h00, "unmapped");
		end_sim();
	end
endmodule // interrupt_flag_registers_bench
